// ==== core/event_router_defines.svh ====
`ifndef EVENT_ROUTER_DEFINES_SVH
`define EVENT_ROUTER_DEFINES_SVH

// channel, generator and user counts
`define ER_ASYNC_CH 2
`define ER_SYNC_CH 1
`define ER_ASYNC_GEN 18
`define ER_SYNC_GEN 20
`define ER_ASYNC_USERS 11
`define ER_SYNC_USERS 2
// source selector encodings: zero means off, n selects generator n-1
`define ER_SRC_OFF 8'h00
// user selector encodings
`define ER_USR_OFF 8'h00
`define ER_USR_SYNC0 8'h01
`define ER_USR_ASYNC0 8'h03
`define ER_USR_ASYNC1 8'h04
// async-capable users that drive the event pins
`define ER_PIN_USER_BASE 8
`define ER_PIN_COUNT 3

`endif

// ==== core/event_router_pkg.sv ====
package event_router_pkg;
  typedef logic [7:0] sel_type;
endpackage : event_router_pkg

// ==== core/channel_source_mux.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "event_router_defines.svh"

// picks one generator per channel and applies a one-cycle software inversion
module channel_source_mux #(
  parameter int gens = 18
) (
  // generators
  input wire logic [gens-1:0] gen_i,
  // selection and strobe
  input wire event_router_pkg::sel_type sel_i,
  input wire logic invert_i,
  // channel
  output logic chan_o
);
  logic picked;
  always_comb begin
    picked = 1'b0;
    for (int g = 0; g < gens; g++) begin
      if (sel_i == 8'(g + 1)) begin
        picked = gen_i[g];
      end
    end
    chan_o = picked ^ invert_i;
  end
endmodule : channel_source_mux
`default_nettype wire

// ==== core/event_routing_unit.sv ====
// How it works
// - each channel carries exactly one selected generator
// - two async channels and one sync
// - generator pulse or level passes unchanged
// - async channels async sources, sync sync
// - source selectors reset to off
// - each user has own channel multiplexer
// - async users also take sync channels
// - user multiplexers reset to off
// - strobe inverts channel for one cycle
// - written one bit strobes matching channel
// - users see strobes like generator events
// - registers clocked, user events registered after combinational routing
// - no strobe while peripheral clock halted
// - three async users (8 to 10) drive event pins
// - sync-only users select only sync channels
// - debug mode leaves router untouched
`timescale 1ns/100ps
`default_nettype none
`include "event_router_defines.svh"

module event_routing_unit (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // generators
  input wire logic [`ER_ASYNC_GEN-1:0] async_gen_i,
  input wire logic [`ER_SYNC_GEN-1:0] sync_gen_i,
  // configuration writes
  input wire logic async_src_we_i,
  input wire logic [0:0] async_src_idx_i,
  input wire logic sync_src_we_i,
  input wire logic async_user_we_i,
  input wire logic [3:0] async_user_idx_i,
  input wire logic sync_user_we_i,
  input wire logic [0:0] sync_user_idx_i,
  input wire event_router_pkg::sel_type wdata_i,
  // software strobes
  input wire logic async_trig_we_i,
  input wire logic sync_trig_we_i,
  input wire logic [7:0] trig_data_i,
  // debug request has no effect
  input wire logic debug_i,
  // events to users and pins
  output logic [`ER_ASYNC_USERS-1:0] async_user_event_o,
  output logic [`ER_SYNC_USERS-1:0] sync_user_event_o,
  output logic [`ER_PIN_COUNT-1:0] event_pin_output_o,
  // selector readback
  output event_router_pkg::sel_type async_src0_o,
  output event_router_pkg::sel_type async_src1_o,
  output event_router_pkg::sel_type sync_src0_o
);
  event_router_pkg::sel_type async_src_r [`ER_ASYNC_CH];
  event_router_pkg::sel_type async_src_nxt [`ER_ASYNC_CH];
  event_router_pkg::sel_type sync_src_r;
  event_router_pkg::sel_type sync_src_nxt;
  event_router_pkg::sel_type async_user_r [`ER_ASYNC_USERS];
  event_router_pkg::sel_type async_user_nxt [`ER_ASYNC_USERS];
  event_router_pkg::sel_type sync_user_r [`ER_SYNC_USERS];
  event_router_pkg::sel_type sync_user_nxt [`ER_SYNC_USERS];
  logic [`ER_ASYNC_CH-1:0] async_inv_r;
  logic [`ER_ASYNC_CH-1:0] async_inv_nxt;
  logic sync_inv_r;
  logic sync_inv_nxt;
  logic [`ER_ASYNC_USERS-1:0] async_ev_nxt;
  logic [`ER_SYNC_USERS-1:0] sync_ev_nxt;
  logic [`ER_ASYNC_USERS-1:0] async_ev_r;
  logic [`ER_SYNC_USERS-1:0] sync_ev_r;
  logic [`ER_ASYNC_CH-1:0] async_chan;
  logic sync_chan;
  logic debug_unused;

  assign debug_unused = debug_i;

  // configuration and strobe state
  always_comb begin
    async_src_nxt = async_src_r;
    sync_src_nxt = sync_src_r;
    async_user_nxt = async_user_r;
    sync_user_nxt = sync_user_r;
    if (async_src_we_i) begin
      async_src_nxt[async_src_idx_i] = wdata_i;
    end
    if (sync_src_we_i) begin
      sync_src_nxt = wdata_i;
    end
    if (async_user_we_i && async_user_idx_i < 4'(`ER_ASYNC_USERS)) begin
      async_user_nxt[async_user_idx_i] = wdata_i;
    end
    if (sync_user_we_i) begin
      sync_user_nxt[sync_user_idx_i] = (wdata_i == `ER_USR_SYNC0) ? wdata_i : `ER_USR_OFF;
    end
    // strobes last exactly one cycle and never queue
    async_inv_nxt = async_trig_we_i ? trig_data_i[`ER_ASYNC_CH-1:0] : '0;
    sync_inv_nxt = sync_trig_we_i & trig_data_i[0];
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < `ER_ASYNC_CH; i++) begin
        async_src_r[i] <= `ER_SRC_OFF;
      end
      sync_src_r <= `ER_SRC_OFF;
      for (int i = 0; i < `ER_ASYNC_USERS; i++) begin
        async_user_r[i] <= `ER_USR_OFF;
      end
      for (int i = 0; i < `ER_SYNC_USERS; i++) begin
        sync_user_r[i] <= `ER_USR_OFF;
      end
      async_inv_r <= '0;
      sync_inv_r <= 1'b0;
    end else begin
      // strobes exist only on clock edges
      async_src_r <= async_src_nxt;
      sync_src_r <= sync_src_nxt;
      async_user_r <= async_user_nxt;
      sync_user_r <= sync_user_nxt;
      async_inv_r <= async_inv_nxt;
      sync_inv_r <= sync_inv_nxt;
    end
  end

  // channel sources, two async and one sync
  genvar c;
  generate
    for (c = 0; c < `ER_ASYNC_CH; c++) begin : g_async_ch
      channel_source_mux #(.gens(`ER_ASYNC_GEN)) u_src (
        .gen_i(async_gen_i),
        .sel_i(async_src_r[c]),
        .invert_i(async_inv_r[c]),
        .chan_o(async_chan[c])
      );
    end
  endgenerate

  channel_source_mux #(.gens(`ER_SYNC_GEN)) u_sync_src (
    .gen_i(sync_gen_i),
    .sel_i(sync_src_r),
    .invert_i(sync_inv_r),
    .chan_o(sync_chan)
  );

  // per-user multiplexers
  genvar u;
  generate
    for (u = 0; u < `ER_ASYNC_USERS; u++) begin : g_async_user
      always_comb begin
        unique case (async_user_r[u])
          `ER_USR_SYNC0: async_ev_nxt[u] = sync_chan;
          `ER_USR_ASYNC0: async_ev_nxt[u] = async_chan[0];
          `ER_USR_ASYNC1: async_ev_nxt[u] = async_chan[1];
          default: async_ev_nxt[u] = 1'b0;
        endcase
      end
    end
    for (u = 0; u < `ER_SYNC_USERS; u++) begin : g_sync_user
      always_comb begin
        sync_ev_nxt[u] = (sync_user_r[u] == `ER_USR_SYNC0) & sync_chan;
      end
    end
  endgenerate

  // outputs registered as the house style requires
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      async_ev_r <= '0;
      sync_ev_r <= '0;
    end else begin
      async_ev_r <= async_ev_nxt;
      sync_ev_r <= sync_ev_nxt;
    end
  end

  assign async_user_event_o = async_ev_r;
  assign sync_user_event_o = sync_ev_r;
  assign event_pin_output_o = async_ev_r[`ER_PIN_USER_BASE +: `ER_PIN_COUNT];
  assign async_src0_o = async_src_r[0];
  assign async_src1_o = async_src_r[1];
  assign sync_src0_o = sync_src_r;
endmodule : event_routing_unit
`default_nettype wire

// ==== verif/gen_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module gen_model (
  // clock and wanted values
  input wire logic clock_i,
  input wire logic [17:0] alvl_i,
  input wire logic [19:0] spls_i,
  // generator lines
  output logic [17:0] agen_o,
  output logic [19:0] sgen_o
);
  // levels persist, sync requests last one cycle
  always_ff @(posedge clock_i) begin
    agen_o <= alvl_i;
    sgen_o <= spls_i;
  end
endmodule : gen_model
`default_nettype wire

// ==== verif/er_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module er_monitor (
  // clock, reset and requests
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [17:0] async_gen_i,
  input wire logic [19:0] sync_gen_i,
  input wire logic async_src_we_i,
  input wire logic [0:0] async_src_idx_i,
  input wire logic sync_src_we_i,
  input wire logic async_user_we_i,
  input wire logic sync_user_we_i,
  input wire event_router_pkg::sel_type wdata_i,
  input wire logic async_trig_we_i,
  input wire logic sync_trig_we_i,
  // outputs
  input wire logic [10:0] async_user_event_o,
  input wire logic [1:0] sync_user_event_o,
  input wire logic [2:0] event_pin_output_o,
  input wire event_router_pkg::sel_type async_src0_o,
  input wire event_router_pkg::sel_type async_src1_o,
  input wire event_router_pkg::sel_type sync_src0_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  wire logic trig = async_trig_we_i | sync_trig_we_i;
  wire logic quiet = !(trig | async_src_we_i | sync_src_we_i | async_user_we_i | sync_user_we_i);
  wire logic [23:0] src = {async_src0_o, async_src1_o, sync_src0_o};
  wire logic [12:0] ev = {sync_user_event_o, async_user_event_o};
  property p_src0;
    async_src_we_i && !async_src_idx_i[0] |=> async_src0_o == $past(wdata_i);
  endproperty
  a_src0: assert property (p_src0) else $error("source 0 write lost");
  property p_src1;
    async_src_we_i && async_src_idx_i[0] |=> async_src1_o == $past(wdata_i);
  endproperty
  a_src1: assert property (p_src1) else $error("source 1 write lost");
  property p_ssrc;
    sync_src_we_i |=> sync_src0_o == $past(wdata_i);
  endproperty
  a_ssrc: assert property (p_ssrc) else $error("sync source write lost");
  property p_hold;
    !(async_src_we_i || sync_src_we_i) |=> $stable(src);
  endproperty
  a_hold: assert property (p_hold) else $error("source changed unwritten");
  property p_rst;
    $rose(reset_n_i) |-> src == 24'h0 && ev == 13'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("state not off after reset");
  property p_pin;
    event_pin_output_o == async_user_event_o[10:8];
  endproperty
  a_pin: assert property (p_pin) else $error("pin differs from its user");
  property p_still;
    (quiet && $stable(async_gen_i) && $stable(sync_gen_i))[*3] |=> $stable(ev);
  endproperty
  a_still: assert property (p_still) else $error("event without cause");
  property p_off;
    (src == 24'h0 && !trig)[*2] |=> ev == 13'h0;
  endproperty
  a_off: assert property (p_off) else $error("event on unsourced channel");
endmodule : er_monitor
bind event_routing_unit er_monitor i_mon (.*);
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock_i = 1'h0, reset_n_i = 1'h0, debug_i = 1'h0;
  logic async_src_we_i = 1'h0, sync_src_we_i = 1'h0, async_user_we_i = 1'h0, sync_user_we_i = 1'h0;
  logic async_trig_we_i = 1'h0, sync_trig_we_i = 1'h0;
  logic [0:0] async_src_idx_i = 1'h0, sync_user_idx_i = 1'h0;
  logic [3:0] async_user_idx_i = 4'h0;
  logic [7:0] trig_data_i = 8'h0;
  event_router_pkg::sel_type wdata_i = 8'h0, async_src0_o, async_src1_o, sync_src0_o;
  logic [17:0] alvl = 18'h0, async_gen_i;
  logic [19:0] spls = 20'h0, sync_gen_i;
  logic [10:0] async_user_event_o;
  logic [1:0] sync_user_event_o;
  logic [2:0] event_pin_output_o;
  int n_fail = 0;
  int total_checks = 0;
  wire logic [12:0] ev = {sync_user_event_o, async_user_event_o};
  always #2.5 clock_i = ~clock_i;
  gen_model i_gen (.clock_i(clock_i), .alvl_i(alvl), .spls_i(spls), .agen_o(async_gen_i), .sgen_o(sync_gen_i));
  event_routing_unit i_dut (.*);
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input int k, input logic [3:0] i, input logic [7:0] d);
    {async_src_we_i, sync_src_we_i, async_user_we_i, sync_user_we_i} = 4'h8 >> k;
    async_src_idx_i = i[0];
    async_user_idx_i = i;
    sync_user_idx_i = i[0];
    wdata_i = d;
    @(posedge clock_i);
    #1;
    {async_src_we_i, sync_src_we_i, async_user_we_i, sync_user_we_i} = 4'h0;
    // let one edge pass so the next write never reassigns in this time step
    @(posedge clock_i);
    #1;
  endtask : wr
  // one request, then which outputs flipped and for how many cycles
  task automatic poke(input logic [2:0] w, input logic [7:0] d, input logic [12:0] m, input logic [7:0] n);
    logic [12:0] base;
    logic [12:0] seen;
    logic [7:0] cnt;
    base = ev;
    seen = 13'h0;
    cnt = 8'h0;
    {async_trig_we_i, sync_trig_we_i, spls[19]} = w;
    trig_data_i = d;
    debug_i = ~debug_i;
    @(posedge clock_i);
    #1;
    {async_trig_we_i, sync_trig_we_i, spls[19]} = 3'h0;
    seen |= ev ^ base;
    cnt += 8'(ev !== base);
    repeat (5) begin
      @(posedge clock_i);
      #1;
      seen |= ev ^ base;
      cnt += 8'(ev !== base);
    end
    chk(seen, m);
    chk(cnt, n);
  endtask : poke
  task automatic t_reset;
    chk({async_src0_o, async_src1_o, sync_src0_o}, 24'h0);
    chk(ev, 13'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_route;
    wr(2, 4'h0, 8'h03);
    wr(2, 4'h1, 8'h04);
    wr(2, 4'h8, 8'h01);
    wr(2, 4'h9, 8'h03);
    wr(2, 4'ha, 8'h04);
    wr(2, 4'hb, 8'h03);
    wr(3, 4'h0, 8'h01);
    wr(3, 4'h1, 8'h03);
    wr(0, 4'h0, 8'h05);
    wr(0, 4'h1, 8'h12);
    wr(1, 4'h0, 8'h14);
    chk({async_src0_o, async_src1_o, sync_src0_o}, 24'h051214);
    alvl = 18'h20010;
    repeat (3) @(posedge clock_i);
    #1;
    chk(ev, 13'h0603);
    chk(event_pin_output_o, 3'h6);
    poke(3'h1, 8'h00, 13'h0900, 8'h1);
    $display("routing test done");
  endtask : t_route
  task automatic t_strobe;
    poke(3'h4, 8'h01, 13'h0201, 8'h1);
    poke(3'h4, 8'h03, 13'h0603, 8'h1);
    poke(3'h2, 8'h01, 13'h0900, 8'h1);
    poke(3'h6, 8'h00, 13'h0, 8'h0);
    $display("strobe test done");
  endtask : t_strobe
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (4) @(posedge clock_i);
    #1;
    reset_n_i = 1'h1;
    t_reset();
    t_route();
    t_strobe();
    final_report();
  end
  initial begin
    #20000;
    n_fail++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
